/* File: design/packet_serialiser.sv */
// Serialiser that shifts out one readout packet, most significant bit first
`timescale 1ns/10ps
`default_nettype none
module packet_serialiser
   import cmd_mode_pkg::*;
#(
   parameter int MAXLEN = PKT_MAX
) (
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              arst_n,
   // Load side
   input  wire logic              load,
   input  wire logic [MAXLEN-1:0] loadBits,
   input  wire logic [5:0]        loadLen,
   input  wire logic              abort,
   // Serial side
   output logic                   busy,
   output logic                   serOut
);
   logic [MAXLEN-1:0] shiftReg;
   logic [5:0]        remaining;

   // Abort wins over load so a soft reset ends a packet at once
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         shiftReg  <= '0;
         remaining <= '0;
      end else if (abort) begin
         shiftReg  <= '0;
         remaining <= '0;
      end else if (load && remaining == 6'h00) begin
         shiftReg  <= loadBits;
         remaining <= loadLen;
      end else if (remaining != 6'h00) begin
         shiftReg  <= {shiftReg[MAXLEN-2:0], 1'b0};
         remaining <= remaining - 6'h01;
      end
   end

   // Output bit stays low when idle
   assign busy   = (remaining != 6'h00);
   assign serOut = busy & shiftReg[MAXLEN-1];
endmodule
`default_nettype wire

/* File: design/readout_chip_command_mode_control.sv */
// Command decoder and operating mode controller for the strip readout chip
//
// Function
// - Error packet: 000, 7-bit address MSB first, 3-bit code, separator 1.
// - Code 001 no trigger; 100 overflow, cleared by soft reset.
// - Error packets only in acquisition mode.
// - Trigger 110 copies three samples to the readout buffer.
// - Fast: 101 then 0100 soft reset or 0010 crossing clear.
// - Slow packet: 101 0111, count, address, select, optional data.
// - Slow commands act only on own or all-ones address.
// - Decode every slow packet fully, even unaddressed.
// - Eight-bit count after prefix gives length.
// - Six-bit select picks register or instruction.
// - Write data sixteen bits MSB first; mask write longer.
// - Write selects per register; mask write count 8D.
// - Instructions: input test, acquire, calibration pulse.
// - Read selects per register; mask read not implemented.
// - Three modes; ID reporting after power-up reset.
// - ID mode answers trigger with address and configuration-1.
// - Any register write drops to ID reporting mode.
// - Enable enters acquisition; any read except mask read enters read-back.
// - Feed-through bit clear and master: clock drives data output.
// - Power-up reset is asynchronous, loads all defaults.
// - Soft reset clears buffers and counters, aborts sending, keeps configuration.
// - Crossing clear zeroes only the crossing counter.
// - Read-back: 000, address, 010, 5-bit code, two bytes each plus one.
`timescale 1ns/10ps
`default_nettype none
module readout_chip_command_mode_control
   import cmd_mode_pkg::*;
#(
   parameter int MASK_BITS = 128,
   parameter int XCNT_W    = 8
) (
   // Clock and power-up reset
   input  wire logic                 ref_clk,
   input  wire logic                 arst_n,
   // Serial command input and static straps
   input  wire logic                 cmdIn,
   input  wire logic [ADDR_W-1:0]    chipAddr,
   input  wire logic                 isMaster,
   input  wire logic                 feedThroughOff,
   // Error sources and answer request from the readout logic
   input  wire logic                 noTriggerErr,
   input  wire logic                 overflowEvent,
   input  wire logic                 readoutRequest,
   // Read-only register contents supplied by the chip
   input  wire logic [DATA_W-1:0]    fuseValue,
   input  wire logic [DATA_W-1:0]    status1Value,
   input  wire logic [DATA_W-1:0]    status2Value,
   // Register contents
   output logic [NUM_WREG*DATA_W-1:0] regFile,
   output logic [MASK_BITS-1:0]      channelMask,
   // Mode and pulses
   output logic [1:0]                opMode,
   output logic                      level_one_trigger,
   output logic [1:0]                sampleCopies,
   output logic                      softReset,
   output logic                      crossing_counter_clear,
   output logic [XCNT_W-1:0]         crossingCount,
   output logic                      inputTestPulse,
   output logic                      calPulse,
   output logic                      overflowFlag,
   // Data output
   output logic                      dataOut
);
   typedef enum logic [2:0] {S_IDLE, S_PRE, S_FAST, S_CNT, S_BODY} dec_state_e;

   dec_state_e        decState;
   op_mode_e          mode;
   logic [2:0]        preShift;
   logic [3:0]        fastShift;
   logic [2:0]        bitIdx;
   logic [CNT_W-1:0]  bitCount;
   logic [CNT_W-1:0]  bodyIdx;
   logic [CNT_W-1:0]  bodyLen;
   logic [ADDR_W+SEL_W-1:0] headShift;
   logic [ADDR_W+SEL_W-1:0] headNow;
   logic [MASK_BITS-1:0]    dataShift;
   logic              pktDone;
   logic              addressed;
   logic [ADDR_W-1:0] pktAddr;
   logic [SEL_W-1:0]  pktSel;
   logic [3:0]        wIdx;
   logic              isRead;
   logic [DATA_W-1:0] readValue;
   logic [4:0]        readCode;
   logic [DATA_W-1:0] lastRead;
   logic [4:0]        lastCode;
   logic              trigHit;
   logic              serBusy;
   logic              serBit;
   logic              serLoad;
   logic [PKT_MAX-1:0] serBits;
   logic [5:0]        serLen;

   // Map a write select code to a register index
   function automatic logic [3:0] write_index(input logic [5:0] sel);
      if      (sel == SEL_W_CFG1)  write_index = 4'h0;
      else if (sel == SEL_W_CAL)   write_index = 4'h1;
      else if (sel == SEL_W_THR)   write_index = 4'h2;
      else if (sel == SEL_W_BIAS1) write_index = 4'h3;
      else if (sel == SEL_W_OFS)   write_index = 4'h4;
      else if (sel == SEL_W_BIAS2) write_index = 4'h5;
      else if (sel == SEL_W_BIAS3) write_index = 4'h6;
      else if (sel == SEL_W_CFG2)  write_index = 4'h7;
      else if (sel == SEL_W_LAT)   write_index = 4'h8;
      else                         write_index = WIDX_NONE;
   endfunction

   // Read code is the select with bit 0 dropped
   function automatic logic is_read_sel(input logic [5:0] sel);
      is_read_sel = (sel == SEL_R_CFG1) || (sel == SEL_R_FUSE) || (sel == SEL_R_THR) ||
                    (sel == SEL_R_BIAS1) || (sel == SEL_R_OFS) || (sel == SEL_R_BIAS2) ||
                    (sel == SEL_R_BIAS3) || (sel == SEL_R_CFG2) || (sel == SEL_R_LAT) ||
                    (sel == SEL_R_CAL) || (sel == SEL_R_STAT1) || (sel == SEL_R_STAT2);
   endfunction

   // Header including the bit on the line, so data-less packets decode on their last bit
   assign headNow   = (decState == S_BODY && bodyIdx < 8'(ADDR_W + SEL_W)) ?
                      {headShift[ADDR_W+SEL_W-2:0], cmdIn} : headShift;
   assign pktAddr   = headNow[ADDR_W+SEL_W-1:SEL_W];
   assign pktSel    = headNow[SEL_W-1:0];
   assign addressed = (pktAddr == chipAddr) || (pktAddr == BROADCAST);
   assign wIdx      = write_index(pktSel);
   assign isRead    = is_read_sel(pktSel);
   assign readCode  = pktSel[5:1];
   assign pktDone   = (decState == S_BODY) && (bodyIdx == bodyLen - 8'h01);

   // Register selected for read-back; mask read returns nothing
   always_comb begin
      readValue = ZERO16;
      if      (pktSel == SEL_R_FUSE)  readValue = fuseValue;
      else if (pktSel == SEL_R_STAT1) readValue = status1Value;
      else if (pktSel == SEL_R_STAT2) readValue = status2Value;
      else if (write_index({pktSel[5:1], 1'b0}) != WIDX_NONE)
         readValue = regFile[write_index({pktSel[5:1], 1'b0})*DATA_W +: DATA_W];
   end

   // ==========================================================
   // Serial command decoder, one bit per edge
   // ==========================================================
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         decState  <= S_IDLE;
         preShift  <= '0;
         fastShift <= '0;
         bitIdx    <= '0;
         bitCount  <= '0;
         bodyIdx   <= '0;
         bodyLen   <= '0;
         headShift <= '0;
         dataShift <= '0;
      end else begin
         case (decState)
            S_IDLE: begin
               // A leading one starts any command
               if (cmdIn) begin
                  decState <= S_PRE;
                  preShift <= {2'b00, 1'b1};
                  bitIdx   <= 3'h1;
               end
            end
            S_PRE: begin
               preShift <= {preShift[1:0], cmdIn};
               bitIdx   <= 3'h0;
               if (bitIdx == 3'h2) begin
                  if ({preShift[1:0], cmdIn} == CTRL_PREFIX) decState <= S_FAST;
                  else                                        decState <= S_IDLE;
               end else begin
                  bitIdx <= bitIdx + 3'h1;
               end
            end
            S_FAST: begin
               fastShift <= {fastShift[2:0], cmdIn};
               bitIdx    <= bitIdx + 3'h1;
               if (bitIdx == 3'h3) begin
                  bitIdx <= 3'h0;
                  if ({fastShift[2:0], cmdIn} == FAST_SLOW) decState <= S_CNT;
                  else                                       decState <= S_IDLE;
               end
            end
            S_CNT: begin
               bitCount <= {bitCount[CNT_W-2:0], cmdIn};
               bitIdx   <= bitIdx + 3'h1;
               if (bitIdx == 3'h7) begin
                  decState <= S_BODY;
                  bodyIdx  <= ZERO8;
                  // Mask writes carry the whole mask
                  if ({bitCount[CNT_W-2:0], cmdIn} == CNT_MASK)
                     bodyLen <= 8'(ADDR_W + SEL_W + MASK_BITS);
                  else if ({bitCount[CNT_W-2:0], cmdIn} == CNT_WRITE)
                     bodyLen <= 8'(ADDR_W + SEL_W + DATA_W);
                  else
                     bodyLen <= 8'(ADDR_W + SEL_W);
               end
            end
            S_BODY: begin
               // Unaddressed chips still walk the whole packet
               bodyIdx <= bodyIdx + 8'h01;
               headShift <= headNow;
               dataShift <= {dataShift[MASK_BITS-2:0], cmdIn};
               if (pktDone) decState <= S_IDLE;
            end
            default: decState <= S_IDLE;
         endcase
      end
   end

   // Word just completed includes the final data bit
   logic [MASK_BITS-1:0] finalData;
   assign finalData = {dataShift[MASK_BITS-2:0], cmdIn};

   // ==========================================================
   // Register file: defaults under power-up reset only
   // ==========================================================
   genvar gi;
   generate
      for (gi = 0; gi < NUM_WREG; gi++) begin : g_reg
         always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
               regFile[gi*DATA_W +: DATA_W] <= ZERO16;
            end else if (pktDone && addressed && bitCount == CNT_WRITE && wIdx == 4'(gi)) begin
               regFile[gi*DATA_W +: DATA_W] <= finalData[DATA_W-1:0];
            end
         end
      end
   endgenerate

   // Channel mask register
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) channelMask <= '0;
      else if (pktDone && addressed && bitCount == CNT_MASK && pktSel == SEL_W_MASK)
         channelMask <= finalData;
   end

   // ==========================================================
   // Operating mode
   // ==========================================================
   // Soft reset keeps the mode, being configuration
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         mode <= MODE_ID;
      end else if (pktDone && addressed) begin
         if ((bitCount == CNT_WRITE && wIdx != WIDX_NONE) ||
             (bitCount == CNT_MASK && pktSel == SEL_W_MASK))
            mode <= MODE_ID;
         else if (bitCount == CNT_NODATA && pktSel == SEL_I_ACQ)
            mode <= MODE_ACQ;
         else if (bitCount == CNT_NODATA && isRead)
            mode <= MODE_READ;
      end
   end

   // Value captured by the last read command
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         lastRead <= ZERO16;
         lastCode <= '0;
      end else if (pktDone && addressed && bitCount == CNT_NODATA && isRead) begin
         lastRead <= readValue;
         lastCode <= readCode;
      end
   end

   // ==========================================================
   // Pulses from decoded commands
   // ==========================================================
   assign trigHit = (decState == S_PRE) && (bitIdx == 3'h2) && ({preShift[1:0], cmdIn} == TRIG_CODE);
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         level_one_trigger      <= 1'b0;
         softReset              <= 1'b0;
         crossing_counter_clear <= 1'b0;
         inputTestPulse         <= 1'b0;
         calPulse               <= 1'b0;
         sampleCopies           <= '0;
      end else begin
         level_one_trigger <= trigHit;
         sampleCopies      <= trigHit ? 2'(SAMPLES) : 2'h0;
         softReset         <= (decState == S_FAST) && (bitIdx == 3'h3) &&
                              ({fastShift[2:0], cmdIn} == FAST_SOFT);
         crossing_counter_clear <= (decState == S_FAST) && (bitIdx == 3'h3) &&
                              ({fastShift[2:0], cmdIn} == FAST_XCLR);
         inputTestPulse    <= pktDone && addressed && bitCount == CNT_NODATA && pktSel == SEL_I_TEST;
         calPulse          <= pktDone && addressed && bitCount == CNT_NODATA && pktSel == SEL_I_CAL;
      end
   end

   // Crossing counter, zeroed by clear or soft reset
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) crossingCount <= '0;
      else if (crossing_counter_clear || softReset) crossingCount <= '0;
      else crossingCount <= crossingCount + 1'b1;
   end

   // Overflow flag is sticky; set beats clear in the same cycle
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) overflowFlag <= 1'b0;
      else if (overflowEvent) overflowFlag <= 1'b1;
      else if (softReset) overflowFlag <= 1'b0;
   end

   // ==========================================================
   // Answer packet assembly
   // ==========================================================
   always_comb begin
      serLoad = 1'b0;
      serBits = '0;
      serLen  = 6'h00;
      if (readoutRequest && !softReset) begin
         case (mode)
            MODE_ACQ: begin
               // Errors only leave the chip while acquiring
               if (overflowFlag || noTriggerErr) begin
                  serLoad = 1'b1;
                  serLen  = 6'(ERR_LEN);
                  serBits[PKT_MAX-1 -: ERR_LEN] = {PKT_HDR, chipAddr,
                     overflowFlag ? ERR_OVFL : ERR_NOTRIG, 1'b1};
               end
            end
            MODE_READ: begin
               serLoad = 1'b1;
               serLen  = 6'(RB_LEN);
               serBits[PKT_MAX-1 -: RB_LEN] = {PKT_HDR, chipAddr, RB_SEP, lastCode,
                  lastRead[15:8], 1'b1, lastRead[7:0], 1'b1};
            end
            default: begin
               serLoad = 1'b1;
               serLen  = 6'(ID_LEN);
               serBits[PKT_MAX-1 -: ID_LEN] = {PKT_HDR, chipAddr, ID_SEP,
                  regFile[15:8], 1'b1, regFile[7:0], 1'b1};
            end
         endcase
      end
   end

   packet_serialiser #(.MAXLEN(PKT_MAX)) u_ser (
      .ref_clk  (ref_clk),
      .arst_n   (arst_n),
      .load     (serLoad),
      .loadBits (serBits),
      .loadLen  (serLen),
      .abort    (softReset),
      .busy     (serBusy),
      .serOut   (serBit)
   );

   // Feed-through clock replaces data
   assign dataOut = (isMaster && !feedThroughOff) ? ref_clk : serBit;
   assign opMode  = mode;
endmodule
`default_nettype wire

/* File: inc/cmd_mode_pkg.sv */
// Constants shared by the command decoder and its packet serialiser
package cmd_mode_pkg;
   // Command prefixes and fast command codes
   localparam logic [2:0] TRIG_CODE    = 3'h6;
   localparam logic [2:0] CTRL_PREFIX  = 3'h5;
   localparam logic [3:0] FAST_SOFT    = 4'h4;
   localparam logic [3:0] FAST_XCLR    = 4'h2;
   localparam logic [3:0] FAST_SLOW    = 4'h7;
   // Slow command bit counts
   localparam logic [7:0] CNT_WRITE    = 8'h1D;
   localparam logic [7:0] CNT_MASK     = 8'h8D;
   localparam logic [7:0] CNT_NODATA   = 8'h0D;
   // Field widths
   localparam int         ADDR_W       = 7;
   localparam int         SEL_W        = 6;
   localparam int         DATA_W       = 16;
   localparam int         CNT_W        = 8;
   localparam int         HDR_BITS     = 3;
   localparam logic [6:0] BROADCAST    = 7'h7F;
   // Write select codes
   localparam logic [5:0] SEL_W_CFG1   = 6'h00;
   localparam logic [5:0] SEL_W_MASK   = 6'h08;
   localparam logic [5:0] SEL_W_CAL    = 6'h10;
   localparam logic [5:0] SEL_W_THR    = 6'h18;
   localparam logic [5:0] SEL_W_BIAS1  = 6'h38;
   localparam logic [5:0] SEL_W_OFS    = 6'h04;
   localparam logic [5:0] SEL_W_BIAS2  = 6'h3A;
   localparam logic [5:0] SEL_W_BIAS3  = 6'h3C;
   localparam logic [5:0] SEL_W_CFG2   = 6'h0C;
   localparam logic [5:0] SEL_W_LAT    = 6'h14;
   // Instruction select codes
   localparam logic [5:0] SEL_I_TEST   = 6'h20;
   localparam logic [5:0] SEL_I_ACQ    = 6'h28;
   localparam logic [5:0] SEL_I_CAL    = 6'h30;
   // Read select codes
   localparam logic [5:0] SEL_R_CFG1   = 6'h01;
   localparam logic [5:0] SEL_R_MASK   = 6'h09;
   localparam logic [5:0] SEL_R_FUSE   = 6'h1D;
   localparam logic [5:0] SEL_R_THR    = 6'h19;
   localparam logic [5:0] SEL_R_BIAS1  = 6'h39;
   localparam logic [5:0] SEL_R_OFS    = 6'h05;
   localparam logic [5:0] SEL_R_BIAS2  = 6'h3B;
   localparam logic [5:0] SEL_R_BIAS3  = 6'h3D;
   localparam logic [5:0] SEL_R_CFG2   = 6'h0D;
   localparam logic [5:0] SEL_R_LAT    = 6'h15;
   localparam logic [5:0] SEL_R_CAL    = 6'h11;
   localparam logic [5:0] SEL_R_STAT1  = 6'h2D;
   localparam logic [5:0] SEL_R_STAT2  = 6'h35;
   // Write target index, ten slots, nine reached by a write select
   localparam int         NUM_WREG     = 10;
   localparam logic [3:0] WIDX_NONE    = 4'hF;
   // Output packet fields
   localparam logic [2:0] PKT_HDR      = 3'h0;
   localparam logic [2:0] ID_SEP       = 3'h7;
   localparam logic [2:0] RB_SEP       = 3'h2;
   localparam logic [2:0] ERR_NOTRIG   = 3'h1;
   localparam logic [2:0] ERR_OVFL     = 3'h4;
   localparam int         PKT_MAX      = 40;
   localparam int         ERR_LEN      = 14;
   localparam int         ID_LEN       = 31;
   localparam int         RB_LEN       = 36;
   localparam int         SAMPLES      = 3;
   localparam logic [3:0] ZERO4        = 4'h0;
   localparam logic [7:0] ZERO8        = 8'h00;
   localparam logic [15:0] ZERO16      = 16'h0000;
   localparam logic [5:0] ZERO6        = 6'h00;

   typedef enum logic [1:0] {MODE_ID, MODE_READ, MODE_ACQ} op_mode_e;
endpackage

/* File: verif/cmd_mode_asserts.sv */
// Port checker for the command decoder and mode controller
`timescale 1ns/10ps
`default_nettype none
module cmd_mode_asserts
   import cmd_mode_pkg::*;
#(
   parameter int XCNT_W = 8
) (
   // Clock, reset and straps
   input wire logic              ref_clk,
   input wire logic              arst_n,
   input wire logic              isMaster,
   input wire logic              feedThroughOff,
   // Decoder outputs
   input wire logic [1:0]        opMode,
   input wire logic              level_one_trigger,
   input wire logic [1:0]        sampleCopies,
   input wire logic              softReset,
   input wire logic              crossing_counter_clear,
   input wire logic [XCNT_W-1:0] crossingCount,
   input wire logic              calPulse,
   input wire logic              overflowFlag,
   input wire logic              dataOut
);
   // ==========================
   // Timing relations
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   chk_trig_copies: assert property (level_one_trigger |-> sampleCopies == 2'h3)
      else $error("copy count wrong on trigger");
   chk_copies_idle: assert property (!level_one_trigger |-> sampleCopies == 2'h0)
      else $error("copies without trigger");
   chk_trig_spacing: assert property (level_one_trigger |=> !level_one_trigger [*2])
      else $error("triggers closer than one code");
   chk_soft_zero: assert property (softReset |-> ##[0:1] crossingCount == '0)
      else $error("soft reset left crossing count");
   chk_xclr_zero: assert property (crossing_counter_clear |-> ##[0:1] crossingCount == '0)
      else $error("crossing clear left count");
   chk_ovfl_clear: assert property ($fell(overflowFlag) |-> softReset || $past(softReset))
      else $error("overflow dropped without soft reset");
   chk_mode_legal: assert property (opMode != 2'h3)
      else $error("illegal mode code");
   chk_cal_single: assert property (calPulse |=> !calPulse)
      else $error("calibration pulse too long");
   // Falling edge: a fed-through clock reads high
   chk_feed_clock: assert property (@(negedge ref_clk) disable iff (!arst_n)
      isMaster && !feedThroughOff |-> dataOut) else $error("clock not fed through");
endmodule
bind readout_chip_command_mode_control cmd_mode_asserts #(.XCNT_W(XCNT_W)) u_cmd_mode_asserts (.ref_clk,
   .arst_n, .isMaster, .feedThroughOff, .opMode, .level_one_trigger, .sampleCopies, .softReset,
   .crossing_counter_clear, .crossingCount, .calPulse, .overflowFlag, .dataOut);
`default_nettype wire

/* File: verif/cmd_source.sv */
// Module controller model that serialises commands
`timescale 1ns/10ps
`default_nettype none
module cmd_source (
   // Clock
   input  wire logic ref_clk,
   // Command line
   output logic      cmdOut
);
   // ==========================
   // Idle low keeps the decoder hunting
   initial cmdOut = 1'b0;
   // Whole packets only, never a trigger inside one
   task automatic send(input logic [63:0] b, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge ref_clk);
         cmdOut <= b[i];
      end
      @(posedge ref_clk);
      cmdOut <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: verif/readout_chip_command_mode_control_tb_top.sv */
// Self-checking bench for the command decoder and mode controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin err_count++; \
$display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module readout_chip_command_mode_control_tb_top
   import cmd_mode_pkg::*;
;
   // ==========================
   // Signals
   int                       seed = 32'h9DA8A902;
   int                       err_count = 0, compares = 0, nTrig = 0, nSoft = 0, nXclr = 0, nTest = 0, nCal = 0;
   logic                     ref_clk = 1'b0, arst_n = 1'b0, isMaster = 1'b1, feedThroughOff = 1'b1;
   logic                     noTriggerErr = 1'b0, overflowEvent = 1'b0, readoutRequest = 1'b0;
   logic [6:0]               chipAddr = 7'h0D;
   logic [15:0]              fuseValue = '0, status1Value = '0, status2Value = '0;
   logic [NUM_WREG*DATA_W-1:0] regFile;
   logic [31:0]              channelMask;
   logic [1:0]               opMode, sampleCopies;
   logic [7:0]               crossingCount;
   logic                     cmdIn, level_one_trigger, softReset, crossing_counter_clear;
   logic                     inputTestPulse, calPulse, overflowFlag, dataOut;
   cmd_source u_cmd_source (.ref_clk, .cmdOut(cmdIn));
   // Short mask fits one 64-bit frame
   readout_chip_command_mode_control #(.MASK_BITS(32), .XCNT_W(8)) u_readout_chip_command_mode_control (
      .ref_clk, .arst_n, .cmdIn, .chipAddr, .isMaster, .feedThroughOff, .noTriggerErr, .overflowEvent,
      .readoutRequest, .fuseValue, .status1Value, .status2Value, .regFile, .channelMask, .opMode,
      .level_one_trigger, .sampleCopies, .softReset, .crossing_counter_clear, .crossingCount,
      .inputTestPulse, .calPulse, .overflowFlag, .dataOut);
   always #2 ref_clk = ~ref_clk;
   // Tally pulses; polling misses one-cycle ones
   always @(posedge ref_clk) begin
      nTrig <= nTrig + int'(level_one_trigger === 1'b1);
      nSoft <= nSoft + int'(softReset === 1'b1);
      nXclr <= nXclr + int'(crossing_counter_clear === 1'b1);
      nTest <= nTest + int'(inputTestPulse === 1'b1);
      nCal  <= nCal + int'(calPulse === 1'b1);
   end
   // Fires only on a hang
   initial begin
      #200000;
      err_count++;
      close_out();
   end
   function automatic logic [63:0] slow(logic [7:0] c, logic [6:0] a, logic [5:0] s);
      return {36'h0, CTRL_PREFIX, FAST_SLOW, c, a, s};
   endfunction
   // Send, then settle to a falling edge
   task automatic go(logic [63:0] b, int n);
      u_cmd_source.send(b, n);
      repeat (4) @(negedge ref_clk);
   endtask
   task automatic wr(logic [6:0] a, logic [5:0] s, logic [15:0] d);
      go((slow(CNT_WRITE, a, s) << 16) | 64'(d), 44);
   endtask
   task automatic ins(logic [5:0] s);
      go(slow(CNT_NODATA, chipAddr, s), 28);
   endtask
   // Request an answer and collect n bits
   task automatic cap(int n, output logic [35:0] v);
      v = '0;
      @(posedge ref_clk);
      readoutRequest <= 1'b1;
      @(posedge ref_clk);
      readoutRequest <= 1'b0;
      repeat (n) begin
         @(negedge ref_clk);
         v = {v[34:0], dataOut};
      end
   endtask
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // ==========================
   // Main sequence
   initial begin
      logic [35:0] got;
      logic [15:0] wv [13];
      logic [5:0]  ws [13] = '{SEL_W_CFG1, SEL_W_CAL, SEL_W_THR, SEL_W_BIAS1, SEL_W_OFS, SEL_W_BIAS2,
                               SEL_W_BIAS3, SEL_W_CFG2, SEL_W_LAT, SEL_R_FUSE, SEL_R_STAT1, SEL_R_STAT2, SEL_R_MASK};
      @(posedge ref_clk);
      chipAddr <= 7'($random(seed)) & 7'h3F;
      fuseValue <= 16'($random(seed));
      status1Value <= 16'($random(seed));
      status2Value <= 16'($random(seed));
      repeat (4) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(negedge ref_clk);
      `CHK("mode at reset", MODE_ID, opMode)
      `CHK("regs at reset", '0, regFile)
      ins(SEL_I_ACQ);
      `CHK("acq mode", MODE_ACQ, opMode)
      @(posedge ref_clk);
      overflowEvent <= 1'b1;
      @(posedge ref_clk);
      overflowEvent <= 1'b0;
      cap(14, got);
      `CHK("overflow packet", {22'h0, PKT_HDR, chipAddr, ERR_OVFL, 1'b1}, got)
      for (int i = 0; i < 9; i++) begin
         wv[i] = 16'($random(seed));
         wr(chipAddr, ws[i], wv[i]);
         `CHK("mode after write", MODE_ID, opMode)
      end
      for (int i = 0; i < 9; i++) `CHK("reg", wv[i], regFile[i*16 +: 16])
      cap(31, got);
      `CHK("id packet", {5'h0, PKT_HDR, chipAddr, ID_SEP, wv[0][15:8], 1'b1, wv[0][7:0], 1'b1}, got)
      wr(chipAddr ^ 7'h01, SEL_W_CFG1, 16'hDB6D);
      `CHK("foreign write", wv[0], regFile[15:0])
      `CHK("data seen as trigger", 0, nTrig)
      wv[0] = 16'h3C5A;
      wr(BROADCAST, SEL_W_CFG1, wv[0]);
      `CHK("broadcast write", wv[0], regFile[15:0])
      got = 36'($random(seed));
      go((slow(CNT_MASK, chipAddr, SEL_W_MASK) << 32) | 64'(got[31:0]), 60);
      `CHK("mask write", got[31:0], channelMask)
      wv[9] = fuseValue;
      wv[10] = status1Value;
      wv[11] = status2Value;
      for (int i = 0; i < 13; i++) begin
         int j;
         j = (i == 12) ? 11 : i; // Mask read is ignored, last answer repeats
         ins(ws[i] | 6'h01);
         `CHK("read mode", MODE_READ, opMode)
         cap(36, got);
         `CHK("read packet", {PKT_HDR, chipAddr, RB_SEP, ws[j][5:1], wv[j][15:8], 1'b1, wv[j][7:0], 1'b1}, got)
      end
      go({61'h0, TRIG_CODE}, 3);
      `CHK("trigger count", 1, nTrig)
      ins(SEL_I_TEST);
      ins(SEL_I_CAL);
      `CHK("test pulse", 1, nTest)
      `CHK("cal pulse", 1, nCal)
      ins(SEL_I_ACQ);
      // Short chain settles during the wait
      go({57'h0, CTRL_PREFIX, FAST_SOFT}, 7);
      `CHK("soft pulse", 1, nSoft)
      `CHK("overflow cleared", 1'b0, overflowFlag)
      `CHK("config kept", wv[0], regFile[15:0])
      @(posedge ref_clk);
      noTriggerErr <= 1'b1;
      cap(14, got);
      `CHK("no trigger packet", {22'h0, PKT_HDR, chipAddr, ERR_NOTRIG, 1'b1}, got)
      go({57'h0, CTRL_PREFIX, FAST_XCLR}, 7);
      `CHK("clear pulse", 1, nXclr)
      `CHK("clear keeps mode", MODE_ACQ, opMode)
      @(posedge ref_clk);
      feedThroughOff <= 1'b0;
      repeat (6) @(posedge ref_clk);
      feedThroughOff <= 1'b1;
      close_out();
   end
endmodule
`default_nettype wire
